//--- logic/card_probe_pkg.sv
// constants and types shared by the card-type interrogation logic
package card_probe_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS  = 20;
  localparam int STABLE_TIME_NS = 2000;
  localparam int STABLE_CYC     = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_TIME_NS = 400;
  localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic SW_SEL_RST    = 1'b0;
  localparam logic PIN_LEVEL_RST = 1'b1;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [2:0] {
    CK_NONE     = 3'h0,
    CK_16BIT    = 3'h1,
    CK_CARDBUS  = 3'h2,
    CK_ADAPTER  = 3'h3,
    CK_RESERVED = 3'h4
  } card_kind_t;

  typedef enum logic [3:0] {
    VC_NONE        = 4'h0,
    VC_5           = 4'h1,
    VC_5_33        = 4'h2,
    VC_5_33_XX     = 4'h3,
    VC_XX          = 4'h4,
    VC_CB_33       = 4'h5,
    VC_CB_33_XX    = 4'h6,
    VC_CB_33_XX_YY = 4'h7,
    VC_CB_33_CORE  = 4'h8,
    VC_CB_XX_YY    = 4'h9,
    VC_CB_YY       = 4'ha,
    VC_QUERY       = 4'hb
  } volt_class_t;

  typedef enum logic [2:0] {
    ST_EMPTY     = 3'h0,
    ST_DRIVE_ONE = 3'h1,
    ST_DRIVE_TWO = 3'h2,
    ST_DECIDE    = 3'h3,
    ST_READY     = 3'h4
  } probe_state_t;

endpackage

//--- logic/probe_if.sv
// samples of the socket terminals and the decoded card class
`timescale 1ns/1ns
interface probe_if import card_probe_pkg::*;;
  logic [1:0]  idle_cd;   // detect levels, no sense driven (bit0 = pin one)
  logic [1:0]  idle_vs;   // sense levels, no sense driven
  logic [1:0]  s1_cd;     // detect levels with sense one driven low
  logic [1:0]  s2_cd;     // detect levels with sense two driven low
  card_kind_t  kind;
  volt_class_t volt;

  modport sampler (output idle_cd, idle_vs, s1_cd, s2_cd, input kind, volt);
  modport decoder (input idle_cd, idle_vs, s1_cd, s2_cd, output kind, volt);
endinterface

//--- logic/pin_stable.sv
// holds a pin level once it has stayed unchanged for CYC cycles
`timescale 1ns/1ns
module pin_stable import card_probe_pkg::*; #(
  parameter int CYC = STABLE_CYC
) (
  input  wire logic ref_clk,  // controller clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic pin,      // raw terminal level
  output logic      level,    // filtered level
  output logic      stable    // pin unchanged for CYC cycles
);
  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          cand_ff;
  logic          nxt_cand;
  logic          level_ff;
  logic          nxt_level;
  logic          stable_ff;
  logic          nxt_stable;

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_cand   = cand_ff;
    nxt_level  = level_ff;
    nxt_stable = stable_ff;
    if (pin != cand_ff) begin
      nxt_cand   = pin;
      nxt_cnt    = '0;
      nxt_stable = 1'b0;
    end else if (cnt_ff == CW'(CYC - 1)) begin
      nxt_level  = cand_ff;
      nxt_stable = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff    <= '0;
      cand_ff   <= PIN_LEVEL_RST;
      level_ff  <= PIN_LEVEL_RST;
      stable_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      cand_ff   <= nxt_cand;
      level_ff  <= nxt_level;
      stable_ff <= nxt_stable;
    end
  end

  assign level  = level_ff;
  assign stable = stable_ff;
endmodule // pin_stable

//--- logic/pattern_decode.sv
// decodes the four-terminal pattern into interface kind and voltage class
`timescale 1ns/1ns
module pattern_decode import card_probe_pkg::*; (
  probe_if.decoder p  // sampled terminal pattern in, class out
);
  logic gnd_cd1, gnd_cd2, gnd_vs1, gnd_vs2, open_vs1, open_vs2;
  logic t11, t12, t21, t22;

  always_comb begin
    // a tie shows as a detect that idles high and follows the driven sense
    t11 = p.idle_cd[0] & ~p.s1_cd[0] &  p.s2_cd[0];
    t12 = p.idle_cd[0] &  p.s1_cd[0] & ~p.s2_cd[0];
    t21 = p.idle_cd[1] & ~p.s1_cd[1] &  p.s2_cd[1];
    t22 = p.idle_cd[1] &  p.s1_cd[1] & ~p.s2_cd[1];
    gnd_cd1  = ~p.idle_cd[0];
    gnd_cd2  = ~p.idle_cd[1];
    gnd_vs1  = ~p.idle_vs[0];
    gnd_vs2  = ~p.idle_vs[1];
    open_vs1 = p.idle_vs[0] & ~t11 & ~t21;
    open_vs2 = p.idle_vs[1] & ~t12 & ~t22;
    p.kind = CK_RESERVED;
    p.volt = VC_NONE;
    if (gnd_cd1 && gnd_cd2) begin
      p.kind = CK_16BIT;                                     // see [RL3]
      case ({gnd_vs2, gnd_vs1})
        2'b00:   p.volt = VC_5;
        2'b01:   p.volt = VC_5_33;
        2'b11:   p.volt = VC_5_33_XX;
        2'b10:   p.volt = VC_XX;
        default: p.volt = VC_NONE;
      endcase
    end else if (gnd_cd2 && t11 && open_vs2) begin           // see [RL4]
      p.kind = CK_CARDBUS;
      p.volt = VC_CB_33;
    end else if (gnd_cd1 && t22 && gnd_vs1) begin
      p.kind = CK_CARDBUS;
      p.volt = VC_CB_33_XX;
    end else if (gnd_cd1 && t21 && gnd_vs2) begin
      p.kind = CK_CARDBUS;
      p.volt = VC_CB_33_XX_YY;
    end else if (gnd_cd1 && t22 && open_vs1) begin           // see [RL5]
      p.kind = CK_CARDBUS;
      p.volt = VC_CB_33_CORE;
    end else if (gnd_cd2 && t12 && open_vs1) begin
      p.kind = CK_CARDBUS;
      p.volt = VC_CB_XX_YY;
    end else if (gnd_cd1 && t21 && open_vs2) begin
      p.kind = CK_CARDBUS;
      p.volt = VC_CB_YY;
    end else if (gnd_cd2 && t11 && gnd_vs2) begin            // see [RL8]
      p.kind = CK_ADAPTER;
      p.volt = VC_QUERY;
    end else begin
      // tie of detect one to sense two with sense one grounded, or junk
      p.kind = CK_RESERVED;                                  // see [RL10]
      p.volt = VC_NONE;
    end
  end
endmodule // pattern_decode

//--- logic/card_interrogator.sv
// card-type interrogation of a cold socket: sequencing, flags, supply gate
//
// Notes on behaviour
// [RL1] A card inserted into a cold unpowered socket starts interrogation, done before supply.
// [RL2] Both detect and both sense terminals together give interface type and voltage needs.
// [RL3] Both detects grounded is 16-bit, with the voltage set by the two sense levels.
// [RL4] A detect tied to a sense is CardBus, voltage set by which pair and the other sense.
// [RL5] Detect two tied to sense two, detect one grounded, sense one open: 3.3 V and 1.8 V core.
// [RL6] With switch-type select at 0 that core card sets the low-voltage card flag.
// [RL7] With switch-type select at 1 that core card sets the alternate-voltage card flag.
// [RL8] Detect one tied to sense one, sense two and detect two grounded is the adapter class.
// [RL9] Adapter media kinds are told apart by query terminals with no extra system hardware.
// [RL10] Detect one tied to sense two, sense one and detect two grounded is reserved, not powered.
// [RL11] Switch-type select resets to the first switch type; setting it picks the 12 V type.
// [RL12] Each sense is driven low in turn while the stable detects are sampled.
`timescale 1ns/1ns
module card_interrogator import card_probe_pkg::*; #(
  parameter int STABLE_CYCLES = STABLE_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic  ref_clk,            // controller clock, 50 MHz
  input  wire logic  rst_n,              // async reset, active low
  input  wire logic  detect_pin_one,     // card detect one, low = grounded
  input  wire logic  detect_pin_two,     // card detect two, low = grounded
  input  wire logic  sense_pin_one_in,   // voltage sense one level
  output logic       sense_pin_one_out,  // sense one drive value (always low)
  output logic       sense_pin_one_oe,   // sense one driven
  input  wire logic  sense_pin_two_in,   // voltage sense two level
  output logic       sense_pin_two_out,  // sense two drive value (always low)
  output logic       sense_pin_two_oe,   // sense two driven
  input  wire logic  socket_powered,     // socket supply already on
  input  wire logic  supply_request,     // software asks for card supply
  input  wire logic  switch_type_load,   // strobe: load switch_type_value
  input  wire logic  switch_type_value,  // new switch-type select
  input  wire logic  [1:0] query_code,   // adapter query terminals
  output logic       switch_type_select, // current switch-type select
  output logic       card_present,       // card seated and classified
  output logic       interrog_done,      // interrogation finished
  output card_kind_t card_kind,          // interface class
  output volt_class_t volt_class,        // voltage class
  output logic       low_volt_card_flag, // 3.3 V capable
  output logic       alt_volt_card_flag, // X.X V capable
  output logic       five_volt_flag,     // 5 V capable
  output logic       yy_volt_flag,       // Y.Y V capable
  output logic       core_supply_flag,   // needs 1.8 V core
  output logic [1:0] adapter_kind,       // adapter media from query terminals
  output logic       supply_enable       // card supply may be switched on
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  // ***********************************************************
  // detect filters
  // ***********************************************************
  logic [1:0] cd_raw;
  logic [1:0] cd_lvl;
  logic [1:0] cd_stb;

  assign cd_raw = {detect_pin_two, detect_pin_one};

  for (genvar i = 0; i < 2; i++) begin : g_cd
    pin_stable #(.CYC(STABLE_CYCLES)) u_filt (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin     (cd_raw[i]),
      .level   (cd_lvl[i]),
      .stable  (cd_stb[i])
    );
  end

  // ***********************************************************
  // pattern decode
  // ***********************************************************
  probe_if pb ();

  pattern_decode u_dec (
    .p (pb.decoder)
  );

  // ***********************************************************
  // state
  // ***********************************************************
  probe_state_t  state_ff,   nxt_state;
  logic [CW-1:0] cnt_ff,     nxt_cnt;
  logic [1:0]    idle_cd_ff, nxt_idle_cd;
  logic [1:0]    idle_vs_ff, nxt_idle_vs;
  logic [1:0]    s1_cd_ff,   nxt_s1_cd;
  logic [1:0]    s2_cd_ff,   nxt_s2_cd;
  card_kind_t    kind_ff,    nxt_kind;
  volt_class_t   volt_ff,    nxt_volt;
  logic          low_ff,     nxt_low;
  logic          alt_ff,     nxt_alt;
  logic          five_ff,    nxt_five;
  logic          yy_ff,      nxt_yy;
  logic          core_ff,    nxt_core;
  logic [1:0]    adapt_ff,   nxt_adapt;
  logic          done_ff,    nxt_done;
  logic          oe1_ff,     nxt_oe1;
  logic          oe2_ff,     nxt_oe2;
  logic          supply_ff,  nxt_supply;
  logic          sel_ff,     nxt_sel;
  logic          seated;
  logic          removed;
  logic          settle_end;

  assign pb.idle_cd = idle_cd_ff;
  assign pb.idle_vs = idle_vs_ff;
  assign pb.s1_cd   = s1_cd_ff;
  assign pb.s2_cd   = s2_cd_ff;

  always_comb begin
    seated     = (&cd_stb) && (cd_lvl != 2'b11);
    removed    = (&cd_stb) && (cd_lvl == 2'b11);
    settle_end = (cnt_ff == CW'(SETTLE_CYCLES - 1));
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_idle_cd = idle_cd_ff;
    nxt_idle_vs = idle_vs_ff;
    nxt_s1_cd   = s1_cd_ff;
    nxt_s2_cd   = s2_cd_ff;
    nxt_kind    = kind_ff;
    nxt_volt    = volt_ff;
    nxt_low     = low_ff;
    nxt_alt     = alt_ff;
    nxt_five    = five_ff;
    nxt_yy      = yy_ff;
    nxt_core    = core_ff;
    nxt_adapt   = adapt_ff;
    nxt_done    = done_ff;
    nxt_sel     = switch_type_load ? switch_type_value : sel_ff;   // see [RL11]
    case (state_ff)
      ST_EMPTY: begin
        nxt_cnt = '0;
        // only a cold socket is probed; a powered one must not see sense drive
        if (seated && !socket_powered) begin                       // see [RL1]
          nxt_idle_cd = cd_lvl;                                    // see [RL12]
          nxt_idle_vs = {sense_pin_two_in, sense_pin_one_in};      // see [RL2]
          nxt_state   = ST_DRIVE_ONE;
        end
      end
      ST_DRIVE_ONE: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (socket_powered) begin
          nxt_state = ST_EMPTY;
        end else if (settle_end) begin
          nxt_s1_cd = cd_raw;                                      // see [RL12]
          nxt_cnt   = '0;
          nxt_state = ST_DRIVE_TWO;
        end
      end
      ST_DRIVE_TWO: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (socket_powered) begin
          nxt_state = ST_EMPTY;
        end else if (settle_end) begin
          nxt_s2_cd = cd_raw;                                      // see [RL12]
          nxt_cnt   = '0;
          nxt_state = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        nxt_kind  = pb.kind;                                       // see [RL2]
        nxt_volt  = pb.volt;
        nxt_five  = pb.volt inside {VC_5, VC_5_33, VC_5_33_XX};
        nxt_low   = pb.volt inside {VC_5_33, VC_5_33_XX, VC_CB_33, VC_CB_33_XX,
                                    VC_CB_33_XX_YY, VC_QUERY};
        nxt_alt   = pb.volt inside {VC_5_33_XX, VC_XX, VC_CB_33_XX,
                                    VC_CB_33_XX_YY, VC_CB_XX_YY};
        nxt_yy    = pb.volt inside {VC_CB_33_XX_YY, VC_CB_XX_YY, VC_CB_YY};
        nxt_core  = (pb.volt == VC_CB_33_CORE);                    // see [RL5]
        if (pb.volt == VC_CB_33_CORE) begin
          nxt_low = !sel_ff;                                       // see [RL6]
          nxt_alt = sel_ff;                                        // see [RL7]
        end
        nxt_adapt = (pb.kind == CK_ADAPTER) ? query_code : 2'h0;   // see [RL9]
        nxt_done  = 1'b1;
        nxt_state = ST_READY;
      end
      ST_READY: begin
        if (removed) begin
          nxt_kind  = CK_NONE;
          nxt_volt  = VC_NONE;
          nxt_low   = 1'b0;
          nxt_alt   = 1'b0;
          nxt_five  = 1'b0;
          nxt_yy    = 1'b0;
          nxt_core  = 1'b0;
          nxt_adapt = 2'h0;
          nxt_done  = 1'b0;
          nxt_state = ST_EMPTY;
        end
      end
      default: nxt_state = ST_EMPTY;
    endcase
    nxt_oe1    = (nxt_state == ST_DRIVE_ONE);                      // see [RL12]
    nxt_oe2    = (nxt_state == ST_DRIVE_TWO);
    // supply only after a finished probe of a known, non-reserved class
    nxt_supply = supply_request && nxt_done && (nxt_state == ST_READY)
                 && (nxt_kind != CK_RESERVED);                     // see [RL1] [RL10]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_EMPTY;
      cnt_ff     <= '0;
      idle_cd_ff <= 2'h3;
      idle_vs_ff <= 2'h3;
      s1_cd_ff   <= 2'h3;
      s2_cd_ff   <= 2'h3;
      kind_ff    <= CK_NONE;
      volt_ff    <= VC_NONE;
      low_ff     <= 1'b0;
      alt_ff     <= 1'b0;
      five_ff    <= 1'b0;
      yy_ff      <= 1'b0;
      core_ff    <= 1'b0;
      adapt_ff   <= 2'h0;
      done_ff    <= 1'b0;
      oe1_ff     <= 1'b0;
      oe2_ff     <= 1'b0;
      supply_ff  <= 1'b0;
      sel_ff     <= SW_SEL_RST;                                    // see [RL11]
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      idle_cd_ff <= nxt_idle_cd;
      idle_vs_ff <= nxt_idle_vs;
      s1_cd_ff   <= nxt_s1_cd;
      s2_cd_ff   <= nxt_s2_cd;
      kind_ff    <= nxt_kind;
      volt_ff    <= nxt_volt;
      low_ff     <= nxt_low;
      alt_ff     <= nxt_alt;
      five_ff    <= nxt_five;
      yy_ff      <= nxt_yy;
      core_ff    <= nxt_core;
      adapt_ff   <= nxt_adapt;
      done_ff    <= nxt_done;
      oe1_ff     <= nxt_oe1;
      oe2_ff     <= nxt_oe2;
      supply_ff  <= nxt_supply;
      sel_ff     <= nxt_sel;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign sense_pin_one_out  = 1'b0;
  assign sense_pin_two_out  = 1'b0;
  assign sense_pin_one_oe   = oe1_ff;
  assign sense_pin_two_oe   = oe2_ff;
  assign switch_type_select = sel_ff;
  assign card_present       = done_ff;
  assign interrog_done      = done_ff;
  assign card_kind          = kind_ff;
  assign volt_class         = volt_ff;
  assign low_volt_card_flag = low_ff;
  assign alt_volt_card_flag = alt_ff;
  assign five_volt_flag     = five_ff;
  assign yy_volt_flag       = yy_ff;
  assign core_supply_flag   = core_ff;
  assign adapter_kind       = adapt_ff;
  assign supply_enable      = supply_ff;

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_one_done;
    state_ff == ST_DRIVE_ONE && settle_end && !socket_powered;
  endsequence
  sequence s_decide_core;
    state_ff == ST_DECIDE && pb.volt == VC_CB_33_CORE;
  endsequence

  supply_after_probe_a: assert property (supply_enable  // see [RL1]
                                         |-> done_ff && kind_ff != CK_NONE)
    else $error("supply enabled before interrogation finished");
  cold_start_a: assert property (state_ff == ST_EMPTY && seated && !socket_powered  // see [RL1]
                                 |=> oe1_ff && !oe2_ff)
    else $error("interrogation did not start on cold insertion");
  drive_order_a: assert property (s_one_done |=> oe2_ff && !oe1_ff ##1 oe2_ff)        // see [RL12]
    else $error("sense two not driven after sense one");
  one_drive_a: assert property (!(oe1_ff && oe2_ff)  // see [RL12]
                                && !(supply_ff && (oe1_ff || oe2_ff)))
    else $error("sense terminals driven together or while powered");
  core_low_flag_a: assert property ((s_decide_core and !sel_ff)  // see [RL6]
                                    |=> low_ff && !alt_ff && core_ff)
    else $error("core card with select 0 did not set low-voltage flag");
  core_alt_flag_a: assert property ((s_decide_core and sel_ff)  // see [RL7]
                                    |=> alt_ff && !low_ff && core_ff)
    else $error("core card with select 1 did not set alternate flag");
  reserved_unpowered_a: assert property (kind_ff == CK_RESERVED |-> !supply_enable)   // see [RL10]
    else $error("reserved card powered");
  sel_reset_a: assert property ($past(!rst_n) |-> sel_ff == SW_SEL_RST)               // see [RL11]
    else $error("switch-type select not at reset value");
  sixteen_bit_a: assert property (state_ff == ST_DECIDE && idle_cd_ff == 2'b00  // see [RL3]
                                  |=> kind_ff == CK_16BIT && done_ff)
    else $error("both detects grounded not classed as 16-bit");
  cardbus_one_high_a: assert property (kind_ff == CK_CARDBUS |-> ^idle_cd_ff)         // see [RL4]
    else $error("cardbus class without exactly one tied detect");
  adapter_query_a: assert property (state_ff == ST_DECIDE && pb.kind == CK_ADAPTER  // see [RL9]
                                    |=> adapter_kind == $past(query_code))
    else $error("adapter kind not taken from query terminals");
endmodule // card_interrogator

//--- dv/card_model.sv
// behavioural card seated in the socket: grounded, open and tied terminals
`timescale 1ns/1ns
module card_model (
  input  wire logic [1:0] cd1_cfg,  // 0 gnd, 1 tie sense one, 2 tie sense two, 3 absent
  input  wire logic [1:0] cd2_cfg,  // same coding for detect two
  input  wire logic [1:0] vs_gnd,   // sense grounded on card, bit0 = pin one
  input  wire logic       oe1,      // host pulls sense one low
  input  wire logic       oe2,      // host pulls sense two low
  output logic            cd1,      // detect one level
  output logic            cd2,      // detect two level
  output logic            vs1,      // sense one level
  output logic            vs2       // sense two level
);
  // open lines read high through the socket pullups, never a stale level
  assign vs1 = !(oe1 | vs_gnd[0]);
  assign vs2 = !(oe2 | vs_gnd[1]);
  // a tie makes the detect follow its sense, so it drops while that sense is driven or grounded on the card
  assign cd1 = (cd1_cfg == 2'h0) ? 1'b0 : (cd1_cfg == 2'h1) ? vs1 :
               (cd1_cfg == 2'h2) ? vs2 : 1'b1;
  assign cd2 = (cd2_cfg == 2'h0) ? 1'b0 : (cd2_cfg == 2'h1) ? vs1 :
               (cd2_cfg == 2'h2) ? vs2 : 1'b1;
endmodule  // card_model

//--- dv/tb.sv
// self-checking bench for the card-type interrogation logic
`timescale 1ns/1ns
module tb;
  import card_probe_pkg::*;
  typedef struct packed {card_kind_t k; volt_class_t v; logic [1:0] q;} note_t;
  logic        ref_clk, rst_n, socket_powered, supply_request;
  logic        switch_type_load, switch_type_value, switch_type_select;
  logic [1:0]  query_code, adapter_kind, cd1_cfg, cd2_cfg, vs_gnd;
  logic        cd1, cd2, vs1, vs2, oe1, oe2, card_present, interrog_done, supply_enable;
  logic        low_volt_card_flag, alt_volt_card_flag, core_supply_flag, done_q;
  logic        five_volt_flag, yy_volt_flag, so1, so2;
  card_kind_t  card_kind;
  volt_class_t volt_class;
  note_t       exp_q[$];
  note_t       e;
  int          n_mismatch, n_checks, cyc;

  card_model u_card (.cd1_cfg(cd1_cfg), .cd2_cfg(cd2_cfg), .vs_gnd(vs_gnd), .oe1(oe1),
    .oe2(oe2), .cd1(cd1), .cd2(cd2), .vs1(vs1), .vs2(vs2));
  // short filters keep each insertion to a few dozen cycles
  card_interrogator #(.STABLE_CYCLES(4), .SETTLE_CYCLES(2)) u_dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .detect_pin_one(cd1), .detect_pin_two(cd2), .sense_pin_one_in(vs1),
    .sense_pin_one_out(so1), .sense_pin_one_oe(oe1), .sense_pin_two_in(vs2),
    .sense_pin_two_out(so2), .sense_pin_two_oe(oe2), .socket_powered(socket_powered),
    .supply_request(supply_request), .switch_type_load(switch_type_load),
    .switch_type_value(switch_type_value), .query_code(query_code),
    .switch_type_select(switch_type_select), .card_present(card_present),
    .interrog_done(interrog_done), .card_kind(card_kind), .volt_class(volt_class),
    .low_volt_card_flag(low_volt_card_flag), .alt_volt_card_flag(alt_volt_card_flag),
    .five_volt_flag(five_volt_flag), .yy_volt_flag(yy_volt_flag),
    .core_supply_flag(core_supply_flag),
    .adapter_kind(adapter_kind), .supply_enable(supply_enable));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ***********************************************************
  // compare and closing tasks
  // ***********************************************************
  task automatic cmp_bit(input string nm, input logic [1:0] x, input logic [1:0] g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic cmp_kind(input card_kind_t x, input card_kind_t g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED card_kind expected %h seen %h", x, g);
    end
  endtask
  task automatic cmp_volt(input volt_class_t x, input volt_class_t g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED volt_class expected %h seen %h", x, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ***********************************************************
  // monitor: one note consumed per completed interrogation
  // ***********************************************************
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    done_q <= (interrog_done === 1'b1);
    if (rst_n && interrog_done === 1'b1 && !done_q) begin
      if (exp_q.size() == 0) begin
        cmp_bit("unexpected_done", 2'h0, 2'h1);
      end else begin
        e = exp_q.pop_front();
        cmp_kind(e.k, card_kind);
        if (e.k != CK_RESERVED) cmp_volt(e.v, volt_class);
        cmp_bit("adapter_kind", e.q, adapter_kind);
      end
    end
    if (oe1 === 1'b1 && oe2 === 1'b1) cmp_bit("sense_overlap", 2'h0, 2'h1);
    if (oe1 === 1'b1 || oe2 === 1'b1) cmp_bit("sense_drive", 2'h0, {so2, so1});
    if (supply_enable === 1'b1 && interrog_done !== 1'b1)
      cmp_bit("early_supply", 2'h0, 2'h1);
    if (cyc == 8000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic wait_done(input logic lvl);
    int n;
    n = 0;
    while (interrog_done !== lvl && n < 300) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    cmp_bit("done_level", lvl, interrog_done);
  endtask

  task automatic set_sel(input logic v);
    @(posedge ref_clk);
    #2;
    switch_type_load = 1'b1;
    switch_type_value = v;
    @(posedge ref_clk);
    #2;
    switch_type_load = 1'b0;
    @(posedge ref_clk);
    #2;
    cmp_bit("switch_type_select", v, switch_type_select);
  endtask

  // hold > 0 seats the card in a powered socket first, which must not probe
  task automatic run_card(input string nm, input logic [1:0] c1, c2, vg,
                          input card_kind_t k, input volt_class_t v, input int hold);
    logic [1:0] q;
    q = 2'($urandom);
    exp_q.push_back('{k, v, (k == CK_ADAPTER) ? q : 2'h0});
    @(posedge ref_clk);
    #2;
    socket_powered = (hold > 0);
    query_code = q;
    vs_gnd = vg;
    cd1_cfg = c1;
    cd2_cfg = c2;
    if (hold > 0) begin
      repeat (hold) @(posedge ref_clk);
      #2;
      cmp_bit("powered_no_probe", 2'h0, {oe1, interrog_done});
      socket_powered = 1'b0;
    end
    wait_done(1'b1);
    repeat (3) @(posedge ref_clk);
    #2;
    cmp_bit("supply_enable", k != CK_RESERVED, supply_enable);
    cmp_bit("five_volt_flag", v inside {VC_5, VC_5_33, VC_5_33_XX}, five_volt_flag);
    cmp_bit("yy_volt_flag", v inside {VC_CB_33_XX_YY, VC_CB_XX_YY, VC_CB_YY},
            yy_volt_flag);
    if (v == VC_CB_33_CORE) begin
      cmp_bit("core_supply_flag", 2'h1, core_supply_flag);
      cmp_bit("low_volt_card_flag", !switch_type_value, low_volt_card_flag);
      cmp_bit("alt_volt_card_flag", switch_type_value, alt_volt_card_flag);
    end
    cd1_cfg = 2'h3;
    cd2_cfg = 2'h3;
    vs_gnd = 2'h0;
    wait_done(1'b0);
    cmp_bit("card_present", 2'h0, card_present);
    $display("test %s done", nm);
  endtask

  initial begin
    rst_n = 1'b0;
    socket_powered = 1'b0;
    supply_request = 1'b1;
    switch_type_load = 1'b0;
    switch_type_value = 1'b0;
    query_code = 2'h0;
    cd1_cfg = 2'h3;
    cd2_cfg = 2'h3;
    vs_gnd = 2'h0;
    done_q = 1'b0;
    cyc = 0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'hec6d));
    repeat (8) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    cmp_bit("select_reset", 2'h0, switch_type_select);
    cmp_kind(CK_NONE, card_kind);
    run_card("p16_5", 2'h0, 2'h0, 2'h0, CK_16BIT, VC_5, 30);
    run_card("p16_5_33", 2'h0, 2'h0, 2'h1, CK_16BIT, VC_5_33, 0);
    run_card("p16_5_33_xx", 2'h0, 2'h0, 2'h3, CK_16BIT, VC_5_33_XX, 0);
    run_card("p16_xx", 2'h0, 2'h0, 2'h2, CK_16BIT, VC_XX, 0);
    run_card("cb_33", 2'h1, 2'h0, 2'h0, CK_CARDBUS, VC_CB_33, 0);
    run_card("cb_33_xx", 2'h0, 2'h2, 2'h1, CK_CARDBUS, VC_CB_33_XX, 0);
    run_card("cb_33_xx_yy", 2'h0, 2'h1, 2'h2, CK_CARDBUS, VC_CB_33_XX_YY, 0);
    run_card("cb_xx_yy", 2'h2, 2'h0, 2'h0, CK_CARDBUS, VC_CB_XX_YY, 0);
    run_card("cb_yy", 2'h0, 2'h1, 2'h0, CK_CARDBUS, VC_CB_YY, 0);
    run_card("adapter", 2'h1, 2'h0, 2'h2, CK_ADAPTER, VC_QUERY, 0);
    run_card("reserved", 2'h2, 2'h0, 2'h1, CK_RESERVED, VC_NONE, 0);
    run_card("core_sel0", 2'h0, 2'h2, 2'h0, CK_CARDBUS, VC_CB_33_CORE, 0);
    set_sel(1'b1);
    run_card("core_sel1", 2'h0, 2'h2, 2'h0, CK_CARDBUS, VC_CB_33_CORE, 0);
    repeat (4) @(posedge ref_clk);
    cmp_bit("notes_left", 2'h0, 2'(exp_q.size()));
    finish_test();
  end
endmodule  // tb
